//--- design/pfs_consts.vh
/*
 * constants for the protection fet sequencing block: widths, timing figures,
 * and state codes.
 * assumes: included by bare name from the design files, one clock at 250 MHz.
 */
`ifndef PFS_CONSTS_VH
`define PFS_CONSTS_VH

// ----------------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------------
`define PFS_CLK_MHZ          250
`define PFS_TICK_US          1
`define PFS_TICK_CYC         (`PFS_TICK_US * `PFS_CLK_MHZ)
`define PFS_PREDISCHARGE_FET_US          100
`define PFS_LD_ON_US         200
`define PFS_LD_OFF_US        800
`define PFS_LD_TIMEOUT_US    100000

// ----------------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------------
`define PFS_CUR_W            16
`define PFS_VOLT_W           16
`define PFS_TIME_W           20

// ----------------------------------------------------------------------------
// predischarge sequencer states, one-hot
// ----------------------------------------------------------------------------
`define PFS_ST_OFF           3'h1
`define PFS_ST_PRE           3'h2
`define PFS_ST_ON            3'h4

// ----------------------------------------------------------------------------
// load detect states, one-hot
// ----------------------------------------------------------------------------
`define PFS_LD_IDLE          4'h1
`define PFS_LD_SRC           4'h2
`define PFS_LD_REST          4'h4
`define PFS_LD_DONE          4'h8

`endif

//--- design/pfs_tick.v
/*
 * pfs_tick: microsecond enable divider for the sequencing block.
 * assumes: one clock, synchronous active-high reset.
 */
`include "pfs_consts.vh"

module pfs_tick #(
   parameter DIV = `PFS_TICK_CYC             // cycles per tick
) (
   input  wire clk_sys_in,                   // system clock
   input  wire rst_in,                       // sync reset, active high
   output reg  tick_out                      // one-cycle pulse per period
);

   // ----------------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------------
   reg [15:0] cnt_q;                         // cycles into the period

   // count up, pulse at terminal value
   always @(posedge clk_sys_in) begin
      if (rst_in) begin
         cnt_q    <= 16'h0000;
         tick_out <= 1'b0;
      end else if (cnt_q == DIV[15:0] - 16'h0001) begin
         cnt_q    <= 16'h0000;
         tick_out <= 1'b1;
      end else begin
         cnt_q    <= cnt_q + 16'h0001;
         tick_out <= 1'b0;
      end
   end

endmodule

//--- design/pfs_fet_ctrl.v
/*
 * pfs_fet_ctrl: gate decisions for high-side charge, discharge, precharge
 * and predischarge fets, with body-diode protection and load-detect recovery.
 * assumes: current and cell voltage come in as same-clock samples from a
 * measurement block; fault latches and comparator output are external pins.
 */
`include "pfs_consts.vh"

module pfs_fet_ctrl #(
   parameter CW          = `PFS_CUR_W,          // current width
   parameter VW          = `PFS_VOLT_W,         // voltage width
   parameter PREDISCHARGE_FET_US     = `PFS_PREDISCHARGE_FET_US,        // predischarge time
   parameter LD_ON_US    = `PFS_LD_ON_US,       // source on time
   parameter LD_OFF_US   = `PFS_LD_OFF_US,      // source off time
   parameter LD_TMO_US   = `PFS_LD_TIMEOUT_US   // recovery timeout
) (
   input  wire                 clk_sys_in,            // system clock
   input  wire                 rst_in,                // sync reset, active high
   input  wire                 series_mode_in,        // 1 series, 0 parallel
   input  wire                 autonomous_in,         // device owns fets
   input  wire                 chg_allow_in,          // charge path allowed
   input  wire                 dsg_allow_in,          // discharge path allowed
   input  wire                 predsg_en_in,          // predischarge enabled
   input  wire                 ld_en_in,              // load detect enabled
   input  wire signed [CW-1:0] current_in,            // signed, + charge
   input  wire signed [CW-1:0] dsg_thresh_in,         // negative threshold
   input  wire signed [CW-1:0] chg_thresh_in,         // positive threshold
   input  wire [VW-1:0]        min_cell_in,           // min cell voltage
   input  wire [VW-1:0]        prechg_thresh_in,      // precharge threshold
   input  wire                 scd_latch_in,          // latched short circuit
   input  wire                 ocd_latch_in,          // latched overcurrent
   input  wire                 ld_above_4v_in,        // async comparator pin
   output reg                  charge_fet_out,        // charge fet gate
   output reg                  precharge_fet_out,     // precharge fet gate
   output reg                  discharge_fet_out,     // discharge fet gate
   output reg                  predischarge_fet_out,  // predischarge fet gate
   output reg                  load_sense_pin_out,    // load sense source on
   output reg                  ld_clear_out,          // pulse: clear fault latch
   output reg                  ld_timeout_out         // load detect timed out
);

   // ----------------------------------------------------------------------
   // tick and input sync
   // ----------------------------------------------------------------------
   wire                  tick;               // 1 us enable
   reg                   ld_s1_q;            // sync stage 1
   reg                   ld_s2_q;            // sync stage 2
   reg                   chg_bd_q;           // charge fet held by protection
   reg                   dsg_bd_q;           // discharge fet held by protection
   reg [2:0]             seq_q;              // predischarge sequencer
   reg [3:0]             ld_q;               // load detect state
   reg [`PFS_TIME_W-1:0] seq_cnt_q;          // predischarge time
   reg [`PFS_TIME_W-1:0] ph_cnt_q;           // source phase time
   reg [`PFS_TIME_W-1:0] tmo_cnt_q;          // overall recovery time
   wire                  bd_ok;              // body-diode switching allowed
   wire                  chg_main;           // charge path in use
   wire                  use_prechg;         // charge via precharge
   wire                  fault;              // any latched discharge fault

   pfs_tick u_tick (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_in),
      .tick_out   (tick)
   );

   // two flip-flops before the comparator is read
   always @(posedge clk_sys_in) begin
      if (rst_in) begin
         ld_s1_q <= 1'b0;
         ld_s2_q <= 1'b0;
      end else begin
         ld_s1_q <= ld_above_4v_in;
         ld_s2_q <= ld_s1_q;
      end
   end

   // ----------------------------------------------------------------------
   // body-diode protection
   // ----------------------------------------------------------------------
   // arrangement and autonomous bits
   assign bd_ok = series_mode_in & autonomous_in;
   assign use_prechg = (min_cell_in < prechg_thresh_in);
   assign chg_main   = chg_allow_in & ~use_prechg;
   assign fault      = scd_latch_in | ocd_latch_in;

   // hold flags track the current against the signed thresholds
   always @(posedge clk_sys_in) begin
      if (rst_in) begin
         chg_bd_q <= 1'b0;
         dsg_bd_q <= 1'b0;
      end else begin
         chg_bd_q <= bd_ok & ~chg_main & (discharge_fet_out | predischarge_fet_out)
                     & (current_in < dsg_thresh_in);
         dsg_bd_q <= bd_ok & ~dsg_allow_in & (charge_fet_out | precharge_fet_out)
                     & (current_in > chg_thresh_in);
      end
   end

   // ----------------------------------------------------------------------
   // predischarge sequencer and gate outputs
   // ----------------------------------------------------------------------
   // predischarge then discharge
   always @(posedge clk_sys_in) begin
      if (rst_in) begin
         seq_q     <= `PFS_ST_OFF;
         seq_cnt_q <= {`PFS_TIME_W{1'b0}};
      end else if (!dsg_allow_in) begin
         seq_q     <= `PFS_ST_OFF;
         seq_cnt_q <= {`PFS_TIME_W{1'b0}};
      end else begin
         case (seq_q)
            `PFS_ST_OFF: begin
               seq_cnt_q <= {`PFS_TIME_W{1'b0}};
               seq_q     <= predsg_en_in ? `PFS_ST_PRE : `PFS_ST_ON;
            end
            `PFS_ST_PRE: begin
               if (tick)
                  seq_cnt_q <= seq_cnt_q + 1'b1;
               if (tick && seq_cnt_q >= PREDISCHARGE_FET_US - 1)
                  seq_q <= `PFS_ST_ON;
            end
            `PFS_ST_ON: seq_q <= `PFS_ST_ON;
            default:    seq_q <= `PFS_ST_OFF;
         endcase
      end
   end

   // registered gate drives
   always @(posedge clk_sys_in) begin
      if (rst_in) begin
         charge_fet_out       <= 1'b0;
         precharge_fet_out    <= 1'b0;
         discharge_fet_out    <= 1'b0;
         predischarge_fet_out <= 1'b0;
      end else begin
         charge_fet_out       <= chg_main | chg_bd_q;
         precharge_fet_out    <= chg_allow_in & use_prechg & ~chg_bd_q;
         discharge_fet_out    <= (seq_q == `PFS_ST_ON) | dsg_bd_q;
         predischarge_fet_out <= (seq_q == `PFS_ST_PRE) & ~dsg_bd_q;
      end
   end

   // ----------------------------------------------------------------------
   // load detect recovery
   // ----------------------------------------------------------------------
   // gated entry
   always @(posedge clk_sys_in) begin
      if (rst_in) begin
         ld_q               <= `PFS_LD_IDLE;
         ph_cnt_q           <= {`PFS_TIME_W{1'b0}};
         tmo_cnt_q          <= {`PFS_TIME_W{1'b0}};
         load_sense_pin_out <= 1'b0;
         ld_clear_out       <= 1'b0;
         ld_timeout_out     <= 1'b0;
      end else begin
         ld_clear_out <= 1'b0;
         if (!(ld_en_in && fault && !discharge_fet_out)) begin
            ld_q               <= `PFS_LD_IDLE;
            load_sense_pin_out <= 1'b0;
            ld_timeout_out     <= 1'b0;
         end else begin
            if (tick)
               tmo_cnt_q <= tmo_cnt_q + 1'b1;
            if (tick)
               ph_cnt_q <= ph_cnt_q + 1'b1;
            case (ld_q)
               `PFS_LD_IDLE: begin
                  ph_cnt_q           <= {`PFS_TIME_W{1'b0}};
                  tmo_cnt_q          <= {`PFS_TIME_W{1'b0}};
                  load_sense_pin_out <= 1'b1;
                  ld_q               <= `PFS_LD_SRC;
               end
               `PFS_LD_SRC: begin
                  if (ld_s2_q) begin
                     ld_clear_out       <= 1'b1;
                     load_sense_pin_out <= 1'b0;
                     ld_q               <= `PFS_LD_IDLE;
                  end else if (tick && tmo_cnt_q >= LD_TMO_US - 1) begin
                     load_sense_pin_out <= 1'b0;
                     ld_timeout_out     <= 1'b1;
                     ld_q               <= `PFS_LD_DONE;
                  end else if (tick && ph_cnt_q >= LD_ON_US - 1) begin
                     load_sense_pin_out <= 1'b0;
                     ph_cnt_q           <= {`PFS_TIME_W{1'b0}};
                     ld_q               <= `PFS_LD_REST;
                  end
               end
               `PFS_LD_REST: begin
                  if (tick && tmo_cnt_q >= LD_TMO_US - 1) begin
                     ld_timeout_out <= 1'b1;
                     ld_q           <= `PFS_LD_DONE;
                  end else if (tick && ph_cnt_q >= LD_OFF_US - 1) begin
                     load_sense_pin_out <= 1'b1;
                     ph_cnt_q           <= {`PFS_TIME_W{1'b0}};
                     ld_q               <= `PFS_LD_SRC;
                  end
               end
               `PFS_LD_DONE: begin
                  load_sense_pin_out <= 1'b0;
                  tmo_cnt_q          <= tmo_cnt_q;
               end
               default: ld_q <= `PFS_LD_IDLE;
            endcase
         end
      end
   end

endmodule

//--- dv/pfs_fet_ctrl_asserts.sv
/* checker: gate, sequencing and load detect relations of pfs_fet_ctrl.
   assumes: bound to pfs_fet_ctrl, one clock, sync active-high reset. */
module pfs_fet_ctrl_chk #(
   parameter CW = 16, // current width
   parameter VW = 16  // voltage width
) (
   input wire logic                 clk_sys_in,       // clock
   input wire logic                 rst_in,           // reset
   input wire logic                 series_mode_in,   // series fets
   input wire logic                 autonomous_in,    // device control
   input wire logic                 chg_allow_in,     // charge wanted
   input wire logic                 dsg_allow_in,     // discharge wanted
   input wire logic                 predsg_en_in,     // predischarge on
   input wire logic                 ld_en_in,         // load detect on
   input wire logic                 scd_latch_in,     // short fault
   input wire logic                 ocd_latch_in,     // overcurrent fault
   input wire logic signed [CW-1:0] current_in,       // + charge
   input wire logic signed [CW-1:0] dsg_thresh_in,    // negative limit
   input wire logic signed [CW-1:0] chg_thresh_in,    // positive limit
   input wire logic [VW-1:0]        min_cell_in,      // min cell
   input wire logic [VW-1:0]        prechg_thresh_in, // precharge limit
   input wire logic                 charge_fet_out,   // gate
   input wire logic                 precharge_fet_out,    // gate
   input wire logic                 discharge_fet_out,    // gate
   input wire logic                 predischarge_fet_out, // gate
   input wire logic                 load_sense_pin_out,   // source on
   input wire logic                 ld_clear_out,     // clear pulse
   input wire logic                 ld_timeout_out    // timed out
);
   default clocking @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);
   // body diode forcing only when series and autonomous
   no_chg_force_a: assert property (((!series_mode_in || !autonomous_in) && !chg_allow_in)[*3]
      |-> !charge_fet_out) else $error("charge fet forced outside series auto");
   no_dsg_force_a: assert property (((!series_mode_in || !autonomous_in) && !dsg_allow_in)[*3]
      |-> !discharge_fet_out) else $error("discharge fet forced outside series auto");
   chg_protect_a: assert property ((series_mode_in && autonomous_in && !chg_allow_in
      && discharge_fet_out && current_in < dsg_thresh_in)[*4] |-> charge_fet_out)
      else $error("charge fet not forced on big discharge");
   dsg_protect_a: assert property ((series_mode_in && autonomous_in && !dsg_allow_in
      && (charge_fet_out || precharge_fet_out) && current_in > chg_thresh_in)[*4]
      |-> discharge_fet_out) else $error("discharge fet not forced on big charge");
   prechg_sel_a: assert property ((chg_allow_in && min_cell_in < prechg_thresh_in
      && current_in >= dsg_thresh_in)[*3]
      |-> precharge_fet_out) else $error("precharge fet not used on low cell");
   chg_sel_a: assert property ((chg_allow_in && min_cell_in >= prechg_thresh_in)[*2]
      |-> charge_fet_out && !precharge_fet_out) else $error("charge path wrong");
   predsg_first_a: assert property ($rose(discharge_fet_out) && predsg_en_in && dsg_allow_in
      && $past(dsg_allow_in, 2)
      |-> $past(predischarge_fet_out)) else $error("discharge fet on without predischarge");
   ld_gate_a: assert property ((!ld_en_in || discharge_fet_out
      || !(scd_latch_in || ocd_latch_in))[*3] |-> !load_sense_pin_out)
      else $error("load sense source on outside recovery");
   ld_tmo_off_a: assert property (ld_timeout_out && $past(ld_timeout_out)
      |-> !load_sense_pin_out) else $error("source on after timeout");
   clr_pulse_a: assert property (ld_clear_out |=> !ld_clear_out)
      else $error("clear pulse longer than one cycle");
endmodule

bind pfs_fet_ctrl pfs_fet_ctrl_chk #(.CW(CW), .VW(VW)) i_chk (
   .clk_sys_in(clk_sys_in), .rst_in(rst_in), .series_mode_in(series_mode_in),
   .autonomous_in(autonomous_in), .chg_allow_in(chg_allow_in), .dsg_allow_in(dsg_allow_in),
   .predsg_en_in(predsg_en_in), .ld_en_in(ld_en_in), .scd_latch_in(scd_latch_in),
   .ocd_latch_in(ocd_latch_in), .current_in(current_in), .dsg_thresh_in(dsg_thresh_in),
   .chg_thresh_in(chg_thresh_in), .min_cell_in(min_cell_in),
   .prechg_thresh_in(prechg_thresh_in), .charge_fet_out(charge_fet_out),
   .precharge_fet_out(precharge_fet_out), .discharge_fet_out(discharge_fet_out),
   .predischarge_fet_out(predischarge_fet_out), .load_sense_pin_out(load_sense_pin_out),
   .ld_clear_out(ld_clear_out), .ld_timeout_out(ld_timeout_out));

//--- dv/pfs_pack_model.sv
/* pack side model: load seen by the load sense current source.
   assumes: same clock as the block; comparator level is the 4 V trip. */
module pfs_pack_model (
   input  wire logic clk_sys_in,         // clock
   input  wire logic load_sense_pin_out, // source on
   input  wire logic load_present_in,    // low-ohm load fitted
   output wire logic ld_above_4v_out     // pin above 4 V
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] rise_q = 2'h0; // pin charge-up time
   // pin climbs past 4 V only with load removed
   always @(posedge clk_sys_in) begin
      if (!load_sense_pin_out || load_present_in) begin
         rise_q <= 2'h0;
      end else if (rise_q != 2'h3) begin
         rise_q <= rise_q + 2'h1;
      end
   end
   assign ld_above_4v_out = (rise_q == 2'h3);
endmodule

//--- dv/testbench.sv
/* testbench: directed sequences for pfs_fet_ctrl with a pack model.
   assumes: short sim timing parameters, tick of 250 cycles. */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_in = 1'b0, rst_in = 1'b1, series_mode_in = 1'b1, autonomous_in = 1'b1;
   logic chg_allow_in = 1'b0, dsg_allow_in = 1'b0, predsg_en_in = 1'b1, ld_en_in = 1'b0;
   logic scd_latch_in = 1'b0, ocd_latch_in = 1'b0, load_present = 1'b1, ld_above_4v_in;
   logic signed [15:0] current_in = 16'sh0, dsg_thresh_in = -16'sd100, chg_thresh_in = 16'sd100;
   logic [15:0] min_cell_in = 16'h0064, prechg_thresh_in = 16'h00c8;
   logic chg_fet, precharge_fet_fet, dsg_fet, predischarge_fet_fet, ld_src, ld_clr, ld_tmo; // outputs
   int errors = 0, compares = 0, cycles = 0;
   always #2 clk_sys_in = ~clk_sys_in;
   pfs_fet_ctrl #(.PREDISCHARGE_FET_US(2), .LD_ON_US(3), .LD_OFF_US(4), .LD_TMO_US(50)) i_dut (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .series_mode_in(series_mode_in),
      .autonomous_in(autonomous_in), .chg_allow_in(chg_allow_in), .dsg_allow_in(dsg_allow_in),
      .predsg_en_in(predsg_en_in), .ld_en_in(ld_en_in), .current_in(current_in),
      .dsg_thresh_in(dsg_thresh_in), .chg_thresh_in(chg_thresh_in), .min_cell_in(min_cell_in),
      .prechg_thresh_in(prechg_thresh_in), .scd_latch_in(scd_latch_in),
      .ocd_latch_in(ocd_latch_in), .ld_above_4v_in(ld_above_4v_in), .charge_fet_out(chg_fet),
      .precharge_fet_out(precharge_fet_fet), .discharge_fet_out(dsg_fet), .predischarge_fet_out(predischarge_fet_fet),
      .load_sense_pin_out(ld_src), .ld_clear_out(ld_clr), .ld_timeout_out(ld_tmo));
   pfs_pack_model i_pack (.clk_sys_in(clk_sys_in), .load_sense_pin_out(ld_src),
      .load_present_in(load_present), .ld_above_4v_out(ld_above_4v_in));
   task automatic final_report;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // hang guard: about three times the expected run
   always @(posedge clk_sys_in) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         errors++;
         final_report();
      end
   end
   task automatic chk(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask
   // wait for source, timeout or clear, bounded
   task automatic wait_for(input int sel, input int lim);
      int n;
      n = 0;
      while (n < lim && !(sel == 0 ? ld_src === 1'b1 : sel == 1 ? ld_tmo === 1'b1 : ld_clr === 1'b1)) begin
         step(1);
         n++;
      end
   endtask
   initial begin
      step(4);
      rst_in = 1'b0;
      step(1);
      chk("charge after reset", 1'b0, chg_fet);
      chk("source after reset", 1'b0, ld_src);
      chg_allow_in = 1'b1;
      step(3);
      chk("precharge low cell", 1'b1, precharge_fet_fet);
      chk("charge low cell", 1'b0, chg_fet);
      min_cell_in = 16'h00c8;
      step(3);
      chk("charge cell ok", 1'b1, chg_fet);
      chk("precharge cell ok", 1'b0, precharge_fet_fet);
      $display("test precharge done");
      dsg_allow_in = 1'b1;
      step(3);
      chk("predischarge first", 1'b1, predischarge_fet_fet);
      chk("discharge waits", 1'b0, dsg_fet);
      step(800);
      chk("discharge on", 1'b1, dsg_fet);
      chk("predischarge off", 1'b0, predischarge_fet_fet);
      $display("test predischarge done");
      chg_allow_in = 1'b0;
      current_in = -16'sd200;
      step(4);
      chk("charge forced", 1'b1, chg_fet);
      current_in = -16'sd100;
      step(4);
      chk("charge released", 1'b0, chg_fet);
      current_in = -16'sd200;
      series_mode_in = 1'b0;
      step(4);
      chk("parallel no force", 1'b0, chg_fet);
      series_mode_in = 1'b1;
      autonomous_in = 1'b0;
      step(4);
      chk("host no force", 1'b0, chg_fet);
      predsg_en_in = 1'b0;
      dsg_allow_in = 1'b0;
      chg_allow_in = 1'b1;
      current_in = 16'sd200;
      step(5);
      chk("host no dsg force", 1'b0, dsg_fet);
      autonomous_in = 1'b1;
      step(5);
      chk("discharge forced", 1'b1, dsg_fet);
      current_in = 16'sd100;
      step(4);
      chk("discharge released", 1'b0, dsg_fet);
      $display("test body diode done");
      chg_allow_in = 1'b0;
      current_in = 16'sh0;
      scd_latch_in = 1'b1;
      ld_en_in = 1'b1;
      wait_for(0, 10);
      chk("source starts", 1'b1, ld_src);
      step(1010);
      chk("source rests", 1'b0, ld_src);
      wait_for(0, 1500);
      chk("source again", 1'b1, ld_src);
      wait_for(1, 14000);
      chk("timeout", 1'b1, ld_tmo);
      chk("source stopped", 1'b0, ld_src);
      ld_en_in = 1'b0;
      scd_latch_in = 1'b0;
      ocd_latch_in = 1'b1;
      load_present = 1'b0;
      step(3);
      ld_en_in = 1'b1;
      wait_for(2, 300);
      chk("fault cleared", 1'b1, ld_clr);
      step(1);
      chk("clear one cycle", 1'b0, ld_clr);
      $display("test load detect done");
      final_report();
   end
endmodule
